// file: logic/i2x_ext.sv
`timescale 1ns/1ps
`default_nettype none
module i2x_ext (
	input  wire logic            sys_clk,     // 125 MHz clock
	input  wire logic            resetn,      // Async reset, low
	input  wire logic            clk_en,      // Freezes state when low
	input  wire logic            psel,        // APB select
	input  wire logic            penable,     // APB enable
	input  wire logic            pwrite,      // APB direction
	input  wire logic [7:0]      paddr,       // APB byte address
	input  wire logic [31:0]     pwdata,      // APB write data
	output logic [31:0]          prdata,      // APB read data
	output logic                 pready,      // APB ready
	output logic                 pslverr,     // APB error
	input  wire i2x_pkg::i2x_eng_t eng,       // Engine events
	input  wire logic [7:0]      rx_data,     // Engine receive word
	input  wire i2x_pkg::i2x_pin_t pin_in,    // Pin input buffers
	output i2x_pkg::i2x_pin_t    pin_out,     // Pin output levels
	output i2x_pkg::i2x_pin_t    pin_oe_n,    // Pin drive enables, low
	output logic                 tx_ready,    // Transmit ready pulse
	output logic                 aas_irq,     // Addressed request
	output logic                 scd_irq      // Stop request
);
	import i2x_pkg::*;

	////////////////////////////////////////////////////////////////////
	// Declarations
	i2x_pin_t    pin_s1;
	i2x_pin_t    pin_s2;
	i2x_pin_t    pin_d;
	logic [31:0] plain_q [PLAIN_N];
	logic [6:0]  int_enable;
	logic        slave_direction;
	logic        addressed_as_slave;
	logic        stop_detected;
	logic        transmit_ready_mode;
	logic        general_pin_mode;
	i2x_pin_t    pin_direction;
	i2x_pin_t    pin_output_value;
	logic        start_seen;
	logic        stop_seen;
	logic        wr_en;
	logic        rd_en;
	logic        setup;
	logic [2:0]  interrupt_source_code;
	logic [31:0] next_rdata;
	logic        next_err;
	logic        loopback;
	logic        plain_hit;
	logic [2:0]  plain_idx;

	////////////////////////////////////////////////////////////////////
	// Bus handshake; a frozen block holds the master in access
	assign pready = clk_en;
	assign setup  = psel && !penable;
	assign wr_en  = clk_en && psel && penable && pwrite;
	assign rd_en  = clk_en && psel && penable && !pwrite;
	assign loopback = plain_q[6][BIT_MODE_LOOP];

	// Plain storage slots for registers whose layout lives in the engine
	always_comb begin
		plain_hit = 1'b1;
		plain_idx = 3'd0;
		unique case (paddr)
			OFS_OWN_ADDRESS:  plain_idx = 3'd0;
			OFS_CLK_LOW:      plain_idx = 3'd1;
			OFS_CLK_HIGH:     plain_idx = 3'd2;
			OFS_DATA_COUNT:   plain_idx = 3'd3;
			OFS_TARGET_ADDR:  plain_idx = 3'd4;
			OFS_TRANSMIT:     plain_idx = 3'd5;
			OFS_MODE_CONTROL: plain_idx = 3'd6;
			OFS_PRESCALER:    plain_idx = 3'd7;
			default:          plain_hit = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Pin synchronisers; stage two and its delayed copy pin_d feed logic
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pin_s1 <= '1;
			pin_s2 <= '1;
			pin_d  <= '1;
		end else if (clk_en) begin
			pin_s1 <= pin_in;
			pin_s2 <= pin_s1;
			pin_d  <= pin_s2;
		end
	end

	// Bus conditions: data edge while clock stays high, whoever drove it
	assign start_seen = pin_s2.scl && pin_d.scl && pin_d.sda && !pin_s2.sda;
	assign stop_seen  = pin_s2.scl && pin_d.scl && !pin_d.sda && pin_s2.sda;

	////////////////////////////////////////////////////////////////////
	// Plain storage words; shift registers have no address at all
	generate
		for (genvar g = 0; g < PLAIN_N; g++) begin : g_plain
			always_ff @(posedge sys_clk or negedge resetn) begin
				if (!resetn) begin
					plain_q[g] <= RST_WORD;
				end else if (wr_en && plain_hit && plain_idx == 3'(g)) begin
					plain_q[g] <= pwdata;
				end
			end
		end
	endgenerate

	// Interrupt enable; bits above 6 are not stored
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			int_enable <= 7'h00;
		end else if (wr_en && paddr == OFS_INT_ENABLE) begin
			int_enable <= pwdata[6:0];
		end
	end

	// Extended mode; only bit 0 exists
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			transmit_ready_mode <= RST_EXT_MODE;
		end else if (wr_en && paddr == OFS_EXT_MODE) begin
			transmit_ready_mode <= pwdata[BIT_EXT_XMODE];
		end
	end

	// Pin function, direction and output value with set/clear aliases
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			general_pin_mode <= 1'b0;
			pin_direction    <= RST_PIN_DIR;
			pin_output_value <= '0;
		end else if (wr_en) begin
			unique case (paddr)
				OFS_PIN_FUNCTION: general_pin_mode <= pwdata[BIT_PIN_GENERAL_PIN_MODE];
				OFS_PIN_DIR:      pin_direction    <= pwdata[1:0];
				OFS_PIN_OUT:      pin_output_value <= pwdata[1:0];
				OFS_PIN_SET:      pin_output_value <= pin_output_value | pwdata[1:0];
				OFS_PIN_CLEAR:    pin_output_value <= pin_output_value & ~pwdata[1:0];
				default:          ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Slave direction: loopback forces zero, a new read address wins
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			slave_direction <= 1'b0;
		end else if (clk_en) begin
			if (loopback) begin
				slave_direction <= 1'b0;
			end else if (eng.addr_match && eng.rw_read) begin
				slave_direction <= 1'b1;
			end else if (start_seen || stop_seen) begin
				slave_direction <= 1'b0;
			end else if (wr_en && paddr == OFS_BUS_STATUS && pwdata[BIT_STS_SLAVE_DIRECTION]) begin
				slave_direction <= 1'b0;
			end
		end
	end

	// Addressed as slave; ends with the transfer
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			addressed_as_slave <= 1'b0;
		end else if (clk_en) begin
			if (eng.addr_match) begin
				addressed_as_slave <= 1'b1;
			end else if (start_seen || stop_seen) begin
				addressed_as_slave <= 1'b0;
			end
		end
	end

	// Stop detected; a stop in the clearing cycle keeps the flag
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			stop_detected <= 1'b0;
		end else if (clk_en) begin
			if (stop_seen) begin
				stop_detected <= 1'b1;
			end else if (rd_en && paddr == OFS_INT_SOURCE && interrupt_source_code == CODE_STOP) begin
				stop_detected <= 1'b0;
			end else if (wr_en && paddr == OFS_BUS_STATUS && pwdata[BIT_STS_SCD]) begin
				stop_detected <= 1'b0;
			end
		end
	end

	// Source code: stop outranks addressed, both need their enable
	always_comb begin
		if (stop_detected && int_enable[BIT_IEN_SCD]) begin
			interrupt_source_code = CODE_STOP;
		end else if (addressed_as_slave && int_enable[BIT_IEN_AAS]) begin
			interrupt_source_code = CODE_AAS;
		end else begin
			interrupt_source_code = CODE_NONE;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read mux, sampled in setup so data comes from flip-flops
	always_comb begin
		next_rdata = RST_WORD;
		next_err   = 1'b0;
		if (plain_hit) begin
			next_rdata = plain_q[plain_idx];
		end else begin
			unique case (paddr)
				OFS_INT_ENABLE: next_rdata[6:0] = int_enable;
				OFS_BUS_STATUS: begin
					next_rdata[BIT_STS_SLAVE_DIRECTION] = slave_direction;
					next_rdata[BIT_STS_AAS]  = addressed_as_slave;
					next_rdata[BIT_STS_SCD]  = stop_detected;
				end
				OFS_RECEIVE_DATA: next_rdata[7:0] = rx_data;
				OFS_INT_SOURCE:   next_rdata[2:0] = interrupt_source_code;
				OFS_EXT_MODE:     next_rdata[BIT_EXT_XMODE] = transmit_ready_mode;
				OFS_PERIPH_ID_1:  next_rdata = ID_WORD_1;
				OFS_PERIPH_ID_2:  next_rdata = ID_WORD_2;
				OFS_PIN_FUNCTION: next_rdata[BIT_PIN_GENERAL_PIN_MODE] = general_pin_mode;
				OFS_PIN_DIR:      next_rdata[1:0] = pin_direction;
				OFS_PIN_INPUT:    next_rdata[1:0] = pin_s2;
				OFS_PIN_OUT:      next_rdata[1:0] = pin_output_value;
				OFS_PIN_SET:      ;
				OFS_PIN_CLEAR:    ;
				default:          next_err = 1'b1;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			prdata  <= RST_WORD;
			pslverr <= 1'b0;
		end else if (clk_en && setup) begin
			prdata  <= pwrite ? RST_WORD : next_rdata;
			pslverr <= next_err;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Transmit ready: mode only steers a slave-transmitter
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			tx_ready <= 1'b0;
		end else if (clk_en) begin
			if (eng.addr_match && eng.rw_read && !loopback) begin
				tx_ready <= 1'b1;
			end else if (slave_direction) begin
				tx_ready <= transmit_ready_mode ? eng.holding_copy
				                                : eng.master_ack;
			end else begin
				tx_ready <= eng.base_ready;
			end
		end
	end

	// Requests are levels of flag and enable together
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			aas_irq <= 1'b0;
			scd_irq <= 1'b0;
		end else if (clk_en) begin
			aas_irq <= addressed_as_slave && int_enable[BIT_IEN_AAS];
			scd_irq <= stop_detected && int_enable[BIT_IEN_SCD];
		end
	end

	// Pin drivers; GPIO applies only while the run bit keeps the engine parked in reset
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pin_out  <= '0;
			pin_oe_n <= '1;
		end else if (clk_en) begin
			if (general_pin_mode && !plain_q[6][BIT_MODE_RUN]) begin
				pin_out  <= pin_output_value;
				pin_oe_n <= ~pin_direction;
			end else begin
				pin_out  <= '0;
				pin_oe_n <= ~eng.drive_low;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	slave_direction_loop_a: assert property (clk_en && loopback |=> !slave_direction)
		else $error("slave direction set in loopback");
	slave_direction_stop_a: assert property (clk_en && stop_seen && !(eng.addr_match && eng.rw_read)
		|=> !slave_direction)
		else $error("slave direction survived a stop");
	slave_direction_set_a: assert property (clk_en && !loopback && eng.addr_match && eng.rw_read
		|=> slave_direction && tx_ready)
		else $error("slave direction or first ready missing");
	scd_set_a: assert property (clk_en && stop_seen |=> stop_detected)
		else $error("stop not flagged");
	scd_rdclr_a: assert property (rd_en && paddr == OFS_INT_SOURCE && interrupt_source_code == CODE_STOP
		&& !stop_seen |=> !stop_detected)
		else $error("stop flag kept after source read");
	xrdy_copy_a: assert property (clk_en && slave_direction && transmit_ready_mode && eng.holding_copy
		|=> tx_ready)
		else $error("no ready on holding copy");
	xrdy_ack_a: assert property (clk_en && slave_direction && !transmit_ready_mode && !eng.master_ack
		&& !(eng.addr_match && eng.rw_read) |=> !tx_ready)
		else $error("ready without master acknowledge");
	irq_gate_a: assert property (clk_en
		|=> scd_irq == ($past(stop_detected) && $past(int_enable[BIT_IEN_SCD])))
		else $error("stop request mismatch");
	aas_gate_a: assert property (!int_enable[BIT_IEN_AAS] && $stable(int_enable) |=> !aas_irq)
		else $error("addressed request while disabled");
	pin_dir_a: assert property (!general_pin_mode && $stable(general_pin_mode) && clk_en
		|=> pin_oe_n == ~$past(eng.drive_low))
		else $error("direction bits acted outside GPIO mode");
	ien_resv_a: assert property (clk_en && setup && !pwrite && paddr == OFS_INT_ENABLE
		|=> prdata[31:7] == 25'h0)
		else $error("reserved enable bits read nonzero");
	slave_direction_w1c_a: assert property (wr_en && paddr == OFS_BUS_STATUS && pwdata[BIT_STS_SLAVE_DIRECTION]
		&& !(eng.addr_match && eng.rw_read) |=> !slave_direction)
		else $error("slave direction kept after write one");
	scd_w1c_a: assert property (wr_en && paddr == OFS_BUS_STATUS && pwdata[BIT_STS_SCD] && !stop_seen
		|=> !stop_detected)
		else $error("stop flag kept after write one");
	gpio_drv_a: assert property (clk_en && general_pin_mode && !plain_q[6][BIT_MODE_RUN]
		|=> pin_oe_n == ~$past(pin_direction) && pin_out == $past(pin_output_value))
		else $error("pin direction or level not applied");
	ext_resv_a: assert property (clk_en && setup && !pwrite && paddr == OFS_EXT_MODE
		|=> prdata[31:1] == 31'h0)
		else $error("reserved extended mode bits read nonzero");
	pin_in_a: assert property (clk_en && setup && !pwrite && paddr == OFS_PIN_INPUT
		|=> prdata[1:0] == $past(pin_s2))
		else $error("pin input read not the sampled levels");

	stop_cov_c: cover property (clk_en && stop_seen ##[1:20] rd_en && paddr == OFS_INT_SOURCE);
	stx_cov_c:  cover property (slave_direction && transmit_ready_mode && eng.holding_copy);
	ack_cov_c:  cover property (slave_direction && !transmit_ready_mode && eng.master_ack);
	gpio_cov_c: cover property (general_pin_mode && !pin_oe_n.sda);
endmodule // i2x_ext
`default_nettype wire

// file: pkg/i2x_pkg.sv
package i2x_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_OWN_ADDRESS  = 8'h00;
	localparam logic [7:0] OFS_INT_ENABLE   = 8'h04;
	localparam logic [7:0] OFS_BUS_STATUS   = 8'h08;
	localparam logic [7:0] OFS_CLK_LOW      = 8'h0c;
	localparam logic [7:0] OFS_CLK_HIGH     = 8'h10;
	localparam logic [7:0] OFS_DATA_COUNT   = 8'h14;
	localparam logic [7:0] OFS_RECEIVE_DATA = 8'h18;
	localparam logic [7:0] OFS_TARGET_ADDR  = 8'h1c;
	localparam logic [7:0] OFS_TRANSMIT     = 8'h20;
	localparam logic [7:0] OFS_MODE_CONTROL = 8'h24;
	localparam logic [7:0] OFS_INT_SOURCE   = 8'h28;
	localparam logic [7:0] OFS_EXT_MODE     = 8'h2c;
	localparam logic [7:0] OFS_PRESCALER    = 8'h30;
	localparam logic [7:0] OFS_PERIPH_ID_1  = 8'h34;
	localparam logic [7:0] OFS_PERIPH_ID_2  = 8'h38;
	localparam logic [7:0] OFS_PIN_FUNCTION = 8'h48;
	localparam logic [7:0] OFS_PIN_DIR      = 8'h4c;
	localparam logic [7:0] OFS_PIN_INPUT    = 8'h50;
	localparam logic [7:0] OFS_PIN_OUT      = 8'h54;
	localparam logic [7:0] OFS_PIN_SET      = 8'h58;
	localparam logic [7:0] OFS_PIN_CLEAR    = 8'h5c;
	// Field positions
	localparam int BIT_IEN_AAS      = 6;
	localparam int BIT_IEN_SCD      = 5;
	localparam int BIT_STS_SLAVE_DIRECTION     = 14;
	localparam int BIT_STS_AAS      = 9;
	localparam int BIT_STS_SCD      = 5;
	localparam int BIT_EXT_XMODE    = 0;
	localparam int BIT_PIN_GENERAL_PIN_MODE   = 0;
	localparam int BIT_MODE_RUN     = 5;
	localparam int BIT_MODE_LOOP    = 6;
	localparam logic [4:0] IEN_BASE_MASK = 5'h1f;
	// Interrupt source codes
	localparam logic [2:0] CODE_NONE = 3'h0;
	localparam logic [2:0] CODE_STOP = 3'h6;
	localparam logic [2:0] CODE_AAS  = 3'h7;
	// Reset values
	localparam logic [31:0] RST_WORD     = 32'h0000_0000;
	localparam logic        RST_EXT_MODE = 1'b1;
	localparam logic [1:0]  RST_PIN_DIR  = 2'h0;
	// Identification words, values arbitrary
	localparam logic [31:0] ID_WORD_1 = 32'h0000_1234;
	localparam logic [31:0] ID_WORD_2 = 32'h0000_0056;
	// Number of plain storage words
	localparam int PLAIN_N = 8;

	// Pin pair, bit 1 data line, bit 0 clock line
	typedef struct packed {
		logic sda;
		logic scl;
	} i2x_pin_t;

	// Events and levels from the serial engine
	typedef struct packed {
		logic     addr_match;   // Own address seen, pulse
		logic     rw_read;      // R/W bit of that address
		logic     holding_copy; // Holding copied to shift, pulse
		logic     master_ack;   // Master acked last byte, pulse
		logic     base_ready;   // Engine's own ready event
		i2x_pin_t drive_low;    // Engine pulls line low
	} i2x_eng_t;
endpackage

// file: testbench/i2x_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module i2x_bus_model (
	input  wire logic              sys_clk,  // Sample clock
	input  wire i2x_pkg::i2x_pin_t pin_out,  // Block pin levels
	input  wire i2x_pkg::i2x_pin_t pin_oe_n, // Block drive enables, low
	output wire i2x_pkg::i2x_pin_t pin_in    // Resolved wire levels
);
	import i2x_pkg::*;
	logic sda_low = 1'b0; // Far side pulls data low
	logic scl_low = 1'b0; // Far side pulls clock low

	// Wired-AND with pull-ups; a released line floats high
	assign pin_in.sda = ~(sda_low | (~pin_oe_n.sda & ~pin_out.sda));
	assign pin_in.scl = ~(scl_low | (~pin_oe_n.scl & ~pin_out.scl));

	////////////////////////////////////////////////////////////////
	// Half of the 160 ns link period; clock stands still between frames
	task automatic half();
		repeat (10) @(posedge sys_clk);
	endtask

	// Data falls while clock high, then clock low
	task automatic start_cond();
		half();
		sda_low <= 1'b1;
		half();
		scl_low <= 1'b1;
		half();
	endtask

	// Data rises while clock high, then the bus idles
	task automatic stop_cond();
		sda_low <= 1'b1;
		scl_low <= 1'b1;
		half();
		scl_low <= 1'b0;
		half();
		sda_low <= 1'b0;
		half();
	endtask
endmodule // i2x_bus_model
`default_nettype wire

// file: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import i2x_pkg::*;
	localparam i2x_eng_t e_rd = '{addr_match: 1'b1, rw_read: 1'b1, default: '0};
	localparam i2x_eng_t e_cp = '{holding_copy: 1'b1, default: '0};
	localparam i2x_eng_t e_ak = '{master_ack: 1'b1, default: '0};
	localparam i2x_eng_t e_bs = '{base_ready: 1'b1, default: '0};
	logic        sys_clk     = 1'b0;
	logic        resetn      = 1'b0;
	logic        clk_en      = 1'b1;
	logic        psel        = 1'b0;
	logic        penable     = 1'b0;
	logic        pwrite      = 1'b0;
	logic [7:0]  paddr       = 8'h00;
	logic [31:0] pwdata      = 32'h0000_0000;
	i2x_eng_t    eng         = '0;
	logic [7:0]  rx_data     = 8'h5a;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	wire i2x_pin_t pin_in;
	i2x_pin_t    pin_out;
	i2x_pin_t    pin_oe_n;
	logic        tx_ready;
	logic        aas_irq;
	logic        scd_irq;
	logic [31:0] rd;
	logic        err;
	int          n_fail      = 0;
	int          comparisons = 0;
	int          cycles      = 0;

	i2x_ext u_dut (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.eng(eng), .rx_data(rx_data), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.tx_ready(tx_ready), .aas_irq(aas_irq), .scd_irq(scd_irq));
	i2x_bus_model u_bus (.sys_clk(sys_clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in(pin_in));

	// 125 MHz clock
	always #4 sys_clk = ~sys_clk;

	// Hang guard, far above the few hundred cycles needed
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_fail = n_fail + 1;
			wrap_up();
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic chk1(input string nm, input logic exp, input logic got);
		chk(nm, {31'h0, exp}, {31'h0, got});
	endtask

	// One APB transfer; waits for pready, never assumes the wait
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) begin
			@(posedge sys_clk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(a, 1'b0, 32'h0000_0000);
		chk($sformatf("reg %h", a), exp, rd);
	endtask

	// One-cycle engine event, then the ready pulse one cycle later
	task automatic ev(input i2x_eng_t e, input logic exp_rdy);
		@(posedge sys_clk);
		eng <= e;
		@(posedge sys_clk);
		eng <= '0;
		#1;
		chk1("tx_ready", exp_rdy, tx_ready);
	endtask

	task automatic settle();
		@(posedge sys_clk);
		#1;
	endtask

	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rdc(OFS_EXT_MODE, 32'h0000_0001);
		rdc(OFS_INT_ENABLE, 32'h0000_0000);
		rdc(OFS_PIN_DIR, 32'h0000_0000);
		rdc(OFS_PIN_FUNCTION, 32'h0000_0000);
		chk("pin_oe_n", 32'h0000_0003, {30'h0, pin_oe_n});
		$display("test reset done");
	endtask

	// Frozen block: no ready, an engine event in the frozen cycle is lost
	task automatic t_freeze();
		@(posedge sys_clk);
		clk_en <= 1'b0;
		eng    <= e_rd;
		@(posedge sys_clk);
		eng    <= '0;
		#1;
		chk1("pready", 1'b0, pready);
		chk1("tx_ready", 1'b0, tx_ready);
		@(posedge sys_clk);
		clk_en <= 1'b1;
		rdc(OFS_BUS_STATUS, 32'h0000_0000);
		$display("test freeze done");
	endtask

	task automatic t_regs();
		wr(OFS_INT_ENABLE, 32'hffff_ffff);
		rdc(OFS_INT_ENABLE, 32'h0000_007f);
		wr(OFS_EXT_MODE, 32'hffff_fffe);
		rdc(OFS_EXT_MODE, 32'h0000_0000);
		wr(OFS_BUS_STATUS, 32'hffff_ffff);
		rdc(OFS_BUS_STATUS, 32'h0000_0000);
		wr(OFS_PIN_DIR, 32'hffff_ffff);
		rdc(OFS_PIN_DIR, 32'h0000_0003);
		wr(OFS_PIN_DIR, 32'h0000_0000);
		wr(OFS_RECEIVE_DATA, 32'h0000_0000);
		rdc(OFS_RECEIVE_DATA, 32'h0000_005a);
		apb(8'h40, 1'b0, 32'h0000_0000);
		chk1("pslverr", 1'b1, err);
		$display("test registers done");
	endtask

	// Addressed for read, both ready modes, then leaving the role
	task automatic t_slave();
		wr(OFS_INT_ENABLE, 32'h0000_0040);
		wr(OFS_EXT_MODE, 32'h0000_0001);
		ev(e_rd, 1'b1);
		settle();
		chk1("aas_irq", 1'b1, aas_irq);
		rdc(OFS_BUS_STATUS, 32'h0000_4200);
		ev(e_cp, 1'b1);
		ev(e_ak, 1'b0);
		wr(OFS_EXT_MODE, 32'h0000_0000);
		ev(e_ak, 1'b1);
		ev(e_cp, 1'b0);
		wr(OFS_BUS_STATUS, 32'h0000_4000);
		rdc(OFS_BUS_STATUS, 32'h0000_0200);
		ev(e_ak, 1'b0);
		ev(e_bs, 1'b1);
		wr(OFS_INT_ENABLE, 32'h0000_0000);
		settle();
		chk1("aas_irq", 1'b0, aas_irq);
		ev(e_rd, 1'b1);
		u_bus.start_cond();
		rdc(OFS_BUS_STATUS, 32'h0000_0000);
		$display("test slave transmit done");
	endtask

	task automatic t_loop();
		wr(OFS_MODE_CONTROL, 32'h0000_0040);
		ev(e_rd, 1'b0);
		apb(OFS_BUS_STATUS, 1'b0, 32'h0000_0000);
		chk1("slave_direction", 1'b0, rd[BIT_STS_SLAVE_DIRECTION]);
		wr(OFS_MODE_CONTROL, 32'h0000_0000);
		$display("test loopback done");
	endtask

	// Stop flag: source-read clear, write-one clear, masked request
	task automatic t_stop();
		wr(OFS_INT_ENABLE, 32'h0000_0020);
		u_bus.stop_cond();
		chk1("scd_irq", 1'b1, scd_irq);
		rdc(OFS_BUS_STATUS, 32'h0000_0020);
		rdc(OFS_INT_SOURCE, 32'h0000_0006);
		rdc(OFS_BUS_STATUS, 32'h0000_0000);
		wr(OFS_INT_ENABLE, 32'h0000_0000);
		u_bus.start_cond();
		u_bus.stop_cond();
		chk1("scd_irq", 1'b0, scd_irq);
		rdc(OFS_BUS_STATUS, 32'h0000_0020);
		wr(OFS_BUS_STATUS, 32'h0000_0020);
		rdc(OFS_BUS_STATUS, 32'h0000_0000);
		$display("test stop done");
	endtask

	// Pin mode entered with the module held in reset
	task automatic t_gpio();
		wr(OFS_MODE_CONTROL, 32'h0000_0000);
		wr(OFS_PIN_OUT, 32'h0000_0001);
		wr(OFS_PIN_DIR, 32'h0000_0002);
		settle();
		chk("pin_oe_n", 32'h0000_0003, {30'h0, pin_oe_n});
		wr(OFS_PIN_FUNCTION, 32'h0000_0001);
		settle();
		chk("pin_oe_n", 32'h0000_0001, {30'h0, pin_oe_n});
		chk1("pin_out_sda", 1'b0, pin_out.sda);
		repeat (3) @(posedge sys_clk);
		rdc(OFS_PIN_INPUT, 32'h0000_0001);
		wr(OFS_PIN_SET, 32'h0000_0002);
		repeat (4) @(posedge sys_clk);
		rdc(OFS_PIN_INPUT, 32'h0000_0003);
		wr(OFS_PIN_FUNCTION, 32'h0000_0000);
		wr(OFS_PIN_DIR, 32'h0000_0003);
		settle();
		chk("pin_oe_n", 32'h0000_0003, {30'h0, pin_oe_n});
		u_bus.start_cond();
		rdc(OFS_PIN_INPUT, 32'h0000_0000);
		u_bus.stop_cond();
		$display("test pins done");
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge sys_clk);
		resetn <= 1'b1;
		t_reset();
		t_freeze();
		t_regs();
		t_slave();
		t_loop();
		t_stop();
		t_gpio();
		wrap_up();
	end
endmodule // tb
`default_nettype wire
